/* hw/toc_top.sv */
// Behaviour
// - PWM modes buffer compare; others bypass it
// - Buffered value loads only at top/bottom
// - Compare writes go to buffer or active
// - Force strobe acts as a compare match, outside PWM modes only
// - Force sets no flag, touches no counter
// - Alternate pins follow state only when selected
// - Counter write blocks next cycle's matches
// - Written top is skipped; counter runs to max
// - Mode changes keep the output state
// - Output mode bits act immediately, unbuffered
// - Mode bits pick match action and pin source
// - Output state is a register apart from pin
// - Reset clears output states to zero
// - Genuine match sets the match flag
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
module toc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic port_level_t0,
  input wire logic [1:0] port_level_t1,
  output logic out_pin_t0,
  output logic [1:0] alt_out_pins_t1,
  output logic override_t0,
  output logic [1:0] override_t1
);

  // Bus state
  toc_pkg::toc_ahb_ap_t ap_q, ap_d; // Address phase held for the data phase
  logic [31:0] hrdata_q, hrdata_d; // Read data, loaded at the address phase

  // Timer 0 state
  toc_pkg::toc_mode_t mode_t0_q, mode_t0_d;
  logic run_t0_q, run_t0_d;
  logic [1:0] out_mode_bits_t0_q, out_mode_bits_t0_d;
  logic [7:0] counter_t0_q, counter_t0_d;
  logic down_t0_q, down_t0_d; // Counting downward in phase mode
  logic blk_t0_q, blk_t0_d; // Match block after counter write
  logic match_flag_t0_q, match_flag_t0_d;

  // Timer 1 state
  toc_pkg::toc_mode_t mode_t1_q, mode_t1_d;
  logic run_t1_q, run_t1_d;
  logic [1:0][1:0] out_mode_bits_t1_q, out_mode_bits_t1_d;
  logic [1:0] pin_select_bit_q, pin_select_bit_d;
  logic [15:0] counter_t1_q, counter_t1_d;
  logic down_t1_q, down_t1_d;
  logic blk_t1_q, blk_t1_d;
  logic [1:0] match_flags_t1_q, match_flags_t1_d;

  // Pin stage
  logic pin_t0_q, pin_t0_d;
  logic [1:0] pin_t1_q, pin_t1_d;
  logic ovr_t0_q, ovr_t0_d;
  logic [1:0] ovr_t1_q, ovr_t1_d;

  // Write strobes for the data phase
  logic wr;
  logic we_ctrl0, we_cnt0, we_cmp0, we_stat0;
  logic we_ctrl1, we_cnt1, we_cmpa, we_cmpb, we_stat1;
  logic force_compare_t0;
  logic [1:0] force_compare_t1;

  // Channel results
  logic [7:0] act_t0;
  logic [15:0] act_t1a, act_t1b;
  logic match_t0, match_t1a, match_t1b;
  logic out_state_t0;
  logic [1:0] out_state_t1;
  toc_pkg::toc_step_t step_t0, step_t1;
  toc_pkg::toc_chan_ctl_t ctl_t0, ctl_t1a, ctl_t1b;

  // One counter step, shared by both timers
  function automatic toc_pkg::toc_step_t count_step(
    input logic [15:0] cnt, input logic [15:0] top, input logic [15:0] maxv,
    input logic down, input toc_pkg::toc_mode_t mode, input logic top_ok);
    toc_pkg::toc_step_t s;
    logic hit;
    s.down = 1'b0;
    s.upd = 1'b0;
    s.cnt = cnt + 16'h0001;
    hit = top_ok && (cnt == top);
    if (mode == toc_pkg::MD_PHASE) begin
      if (down && cnt == 16'h0000) begin
        s.upd = 1'b1; // Turn at bottom, load buffer
      end else if (down || hit || cnt == maxv) begin
        s.down = 1'b1;
        s.cnt = cnt - 16'h0001;
      end
    end else if ((hit && mode != toc_pkg::MD_NORMAL) || cnt == maxv) begin
      s.cnt = 16'h0000;
      s.upd = (mode == toc_pkg::MD_FAST); // Load buffer at top
    end
    return s;
  endfunction

  // Address phase capture and register address decode
  always_comb begin
    ap_d.valid = hsel && htrans[1] && hready;
    ap_d.write = hwrite;
    ap_d.in_range = (haddr[31:8] == 24'h000000);
    ap_d.addr = haddr[7:0];
    wr = ap_q.valid && ap_q.write && ap_q.in_range;
    we_ctrl0 = 1'b0;
    we_cnt0 = 1'b0;
    we_cmp0 = 1'b0;
    we_stat0 = 1'b0;
    we_ctrl1 = 1'b0;
    we_cnt1 = 1'b0;
    we_cmpa = 1'b0;
    we_cmpb = 1'b0;
    we_stat1 = 1'b0;
    if (!wr) begin
      we_ctrl0 = 1'b0; // No write this cycle
    end else if (ap_q.addr == toc_pkg::REG_T0_CTRL) begin
      we_ctrl0 = 1'b1;
    end else if (ap_q.addr == toc_pkg::REG_T0_COUNT) begin
      we_cnt0 = 1'b1;
    end else if (ap_q.addr == toc_pkg::REG_T0_CMP) begin
      we_cmp0 = 1'b1;
    end else if (ap_q.addr == toc_pkg::REG_T0_STAT) begin
      we_stat0 = 1'b1;
    end else if (ap_q.addr == toc_pkg::REG_T1_CTRL) begin
      we_ctrl1 = 1'b1;
    end else if (ap_q.addr == toc_pkg::REG_T1_COUNT) begin
      we_cnt1 = 1'b1;
    end else if (ap_q.addr == toc_pkg::REG_T1_CMPA) begin
      we_cmpa = 1'b1;
    end else if (ap_q.addr == toc_pkg::REG_T1_CMPB) begin
      we_cmpb = 1'b1;
    end else if (ap_q.addr == toc_pkg::REG_T1_STAT) begin
      we_stat1 = 1'b1;
    end
    // Force bits are strobes, never stored
    force_compare_t0 = we_ctrl0 && hwdata[toc_pkg::CTL_FORCEA];
    force_compare_t1[0] = we_ctrl1 && hwdata[toc_pkg::CTL_FORCEA];
    force_compare_t1[1] = we_ctrl1 && hwdata[toc_pkg::CTL_FORCEB];
  end

  // Read data for the address now in its address phase
  always_comb begin
    hrdata_d = hrdata_q;
    if (ap_d.valid && !ap_d.write) begin
      hrdata_d = 32'h00000000; // Unmapped reads give zero
      if (!ap_d.in_range) begin
        hrdata_d = 32'h00000000;
      end else if (ap_d.addr == toc_pkg::REG_T0_CTRL) begin
        hrdata_d[1:0] = mode_t0_q;
        hrdata_d[toc_pkg::CTL_RUN] = run_t0_q;
        hrdata_d[toc_pkg::CTL_OMA_LSB +: 2] = out_mode_bits_t0_q;
      end else if (ap_d.addr == toc_pkg::REG_T0_COUNT) begin
        hrdata_d[7:0] = counter_t0_q;
      end else if (ap_d.addr == toc_pkg::REG_T0_CMP) begin
        hrdata_d[7:0] = act_t0;
      end else if (ap_d.addr == toc_pkg::REG_T0_STAT) begin
        hrdata_d[toc_pkg::STAT_FLAGA] = match_flag_t0_q;
        hrdata_d[toc_pkg::STAT_STATEA] = out_state_t0;
      end else if (ap_d.addr == toc_pkg::REG_T1_CTRL) begin
        hrdata_d[1:0] = mode_t1_q;
        hrdata_d[toc_pkg::CTL_RUN] = run_t1_q;
        hrdata_d[toc_pkg::CTL_OMA_LSB +: 2] = out_mode_bits_t1_q[0];
        hrdata_d[toc_pkg::CTL_OMB_LSB +: 2] = out_mode_bits_t1_q[1];
        hrdata_d[toc_pkg::CTL_SELA] = pin_select_bit_q[0];
        hrdata_d[toc_pkg::CTL_SELB] = pin_select_bit_q[1];
      end else if (ap_d.addr == toc_pkg::REG_T1_COUNT) begin
        hrdata_d[15:0] = counter_t1_q;
      end else if (ap_d.addr == toc_pkg::REG_T1_CMPA) begin
        hrdata_d[15:0] = act_t1a;
      end else if (ap_d.addr == toc_pkg::REG_T1_CMPB) begin
        hrdata_d[15:0] = act_t1b;
      end else if (ap_d.addr == toc_pkg::REG_T1_STAT) begin
        hrdata_d[toc_pkg::STAT_FLAGB:toc_pkg::STAT_FLAGA] = match_flags_t1_q;
        hrdata_d[toc_pkg::STAT_STATEB:toc_pkg::STAT_STATEA] = out_state_t1;
      end
    end
  end

  // Control registers; mode bits take effect at once
  always_comb begin
    mode_t0_d = mode_t0_q;
    run_t0_d = run_t0_q;
    out_mode_bits_t0_d = out_mode_bits_t0_q;
    mode_t1_d = mode_t1_q;
    run_t1_d = run_t1_q;
    out_mode_bits_t1_d = out_mode_bits_t1_q;
    pin_select_bit_d = pin_select_bit_q;
    if (we_ctrl0) begin
      mode_t0_d = toc_pkg::toc_mode_t'(hwdata[1:0]);
      run_t0_d = hwdata[toc_pkg::CTL_RUN];
      out_mode_bits_t0_d = hwdata[toc_pkg::CTL_OMA_LSB +: 2];
    end
    if (we_ctrl1) begin
      mode_t1_d = toc_pkg::toc_mode_t'(hwdata[1:0]);
      run_t1_d = hwdata[toc_pkg::CTL_RUN];
      out_mode_bits_t1_d[0] = hwdata[toc_pkg::CTL_OMA_LSB +: 2];
      out_mode_bits_t1_d[1] = hwdata[toc_pkg::CTL_OMB_LSB +: 2];
      pin_select_bit_d[0] = hwdata[toc_pkg::CTL_SELA];
      pin_select_bit_d[1] = hwdata[toc_pkg::CTL_SELB];
    end
  end

  // Counters; a software write wins and blocks the next cycle
  always_comb begin
    step_t0 = count_step({8'h00, counter_t0_q}, {8'h00, act_t0}, toc_pkg::MAX_T0,
      down_t0_q, mode_t0_q, !blk_t0_q);
    step_t1 = count_step(counter_t1_q, act_t1a, toc_pkg::MAX_T1,
      down_t1_q, mode_t1_q, !blk_t1_q);
    counter_t0_d = counter_t0_q;
    down_t0_d = down_t0_q;
    counter_t1_d = counter_t1_q;
    down_t1_d = down_t1_q;
    if (we_cnt0) begin
      counter_t0_d = hwdata[7:0];
    end else if (run_t0_q) begin
      counter_t0_d = step_t0.cnt[7:0];
      down_t0_d = step_t0.down;
    end
    if (we_cnt1) begin
      counter_t1_d = hwdata[15:0];
    end else if (run_t1_q) begin
      counter_t1_d = step_t1.cnt;
      down_t1_d = step_t1.down;
    end
    blk_t0_d = we_cnt0;
    blk_t1_d = we_cnt1;
  end

  // Match flags: hardware set beats a write-one clear
  always_comb begin
    match_flag_t0_d = match_flag_t0_q;
    match_flags_t1_d = match_flags_t1_q;
    if (we_stat0 && hwdata[toc_pkg::STAT_FLAGA]) begin
      match_flag_t0_d = 1'b0;
    end
    if (we_stat1) begin
      match_flags_t1_d = match_flags_t1_q &
        ~hwdata[toc_pkg::STAT_FLAGB:toc_pkg::STAT_FLAGA];
    end
    if (match_t0) begin
      match_flag_t0_d = 1'b1;
    end
    if (match_t1a) begin
      match_flags_t1_d[0] = 1'b1;
    end
    if (match_t1b) begin
      match_flags_t1_d[1] = 1'b1;
    end
  end

  // Pin source selection through the override path
  always_comb begin
    ovr_t0_d = (out_mode_bits_t0_q != toc_pkg::OM_PORT);
    pin_t0_d = ovr_t0_d ? out_state_t0 : port_level_t0;
    for (int i = 0; i < 2; i++) begin
      ovr_t1_d[i] = (out_mode_bits_t1_q[i] != toc_pkg::OM_PORT) && pin_select_bit_q[i];
      pin_t1_d[i] = ovr_t1_d[i] ? out_state_t1[i] : port_level_t1[i];
    end
  end

  // Channel control bundles; a control write already governs its own force strobe
  always_comb begin
    ctl_t0.pwm = mode_t0_d[1];
    ctl_t0.out_mode = out_mode_bits_t0_d;
    ctl_t0.force_cmp = force_compare_t0;
    ctl_t1a.pwm = mode_t1_d[1];
    ctl_t1a.out_mode = out_mode_bits_t1_d[0];
    ctl_t1a.force_cmp = force_compare_t1[0];
    ctl_t1b.pwm = mode_t1_d[1];
    ctl_t1b.out_mode = out_mode_bits_t1_d[1];
    ctl_t1b.force_cmp = force_compare_t1[1];
  end

  toc_chan #(.W(8)) u_chan_t0 (
    .hclk(hclk), .hresetn(hresetn), .ctl(ctl_t0), .cmp_wr(we_cmp0),
    .cmp_wdata(hwdata[7:0]), .count(counter_t0_q), .running(run_t0_q),
    .block(blk_t0_q), .update_evt(run_t0_q && step_t0.upd),
    .active(act_t0), .match(match_t0), .state(out_state_t0));

  toc_chan #(.W(16)) u_chan_t1a (
    .hclk(hclk), .hresetn(hresetn), .ctl(ctl_t1a), .cmp_wr(we_cmpa),
    .cmp_wdata(hwdata[15:0]), .count(counter_t1_q), .running(run_t1_q),
    .block(blk_t1_q), .update_evt(run_t1_q && step_t1.upd),
    .active(act_t1a), .match(match_t1a), .state(out_state_t1[0]));

  toc_chan #(.W(16)) u_chan_t1b (
    .hclk(hclk), .hresetn(hresetn), .ctl(ctl_t1b), .cmp_wr(we_cmpb),
    .cmp_wdata(hwdata[15:0]), .count(counter_t1_q), .running(run_t1_q),
    .block(blk_t1_q), .update_evt(run_t1_q && step_t1.upd),
    .active(act_t1b), .match(match_t1b), .state(out_state_t1[1]));

  // All registers of the top
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= '0;
      hrdata_q <= 32'h00000000;
      mode_t0_q <= toc_pkg::RST_MODE;
      run_t0_q <= 1'b0;
      out_mode_bits_t0_q <= toc_pkg::RST_OM;
      counter_t0_q <= 8'h00;
      down_t0_q <= 1'b0;
      blk_t0_q <= 1'b0;
      match_flag_t0_q <= 1'b0;
      mode_t1_q <= toc_pkg::RST_MODE;
      run_t1_q <= 1'b0;
      out_mode_bits_t1_q <= {toc_pkg::RST_OM, toc_pkg::RST_OM};
      pin_select_bit_q <= 2'h0;
      counter_t1_q <= 16'h0000;
      down_t1_q <= 1'b0;
      blk_t1_q <= 1'b0;
      match_flags_t1_q <= 2'h0;
      pin_t0_q <= 1'b0;
      pin_t1_q <= 2'h0;
      ovr_t0_q <= 1'b0;
      ovr_t1_q <= 2'h0;
    end else begin
      ap_q <= ap_d;
      hrdata_q <= hrdata_d;
      mode_t0_q <= mode_t0_d;
      run_t0_q <= run_t0_d;
      out_mode_bits_t0_q <= out_mode_bits_t0_d;
      counter_t0_q <= counter_t0_d;
      down_t0_q <= down_t0_d;
      blk_t0_q <= blk_t0_d;
      match_flag_t0_q <= match_flag_t0_d;
      mode_t1_q <= mode_t1_d;
      run_t1_q <= run_t1_d;
      out_mode_bits_t1_q <= out_mode_bits_t1_d;
      pin_select_bit_q <= pin_select_bit_d;
      counter_t1_q <= counter_t1_d;
      down_t1_q <= down_t1_d;
      blk_t1_q <= blk_t1_d;
      match_flags_t1_q <= match_flags_t1_d;
      pin_t0_q <= pin_t0_d;
      pin_t1_q <= pin_t1_d;
      ovr_t0_q <= ovr_t0_d;
      ovr_t1_q <= ovr_t1_d;
    end
  end

  // Outputs; the slave never inserts wait states
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign out_pin_t0 = pin_t0_q;
  assign alt_out_pins_t1 = pin_t1_q;
  assign override_t0 = ovr_t0_q;
  assign override_t1 = ovr_t1_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_flag_sticky: assert property (match_t0 |=> match_flag_t0_q)
    else $error("match did not set flag");
  chk_force_no_flag: assert property (
    (force_compare_t0 && !match_t0 && !we_stat0) |=> $stable(match_flag_t0_q))
    else $error("forced compare touched the flag");
  chk_force_no_count: assert property (
    (force_compare_t0 && !run_t0_q && !we_cnt0) |=> $stable(counter_t0_q))
    else $error("forced compare moved the counter");
  chk_write_blocks: assert property (we_cnt1 |=> !match_t1a && !match_t1b)
    else $error("match not blocked after counter write");
  chk_top_skipped: assert property (
    (run_t1_q && blk_t1_q && mode_t1_q == toc_pkg::MD_FAST && counter_t1_q == act_t1a &&
     counter_t1_q != 16'hFFFF && !we_cnt1) |=> counter_t1_q == $past(counter_t1_q) + 16'h0001)
    else $error("written top was not skipped");
  chk_pin_port: assert property (
    (out_mode_bits_t0_q == toc_pkg::OM_PORT) |=> out_pin_t0 == $past(port_level_t0))
    else $error("pin not handed to port");
  chk_pin_state: assert property (
    (out_mode_bits_t0_q != toc_pkg::OM_PORT) |=> out_pin_t0 == $past(out_state_t0))
    else $error("pin does not follow output state");
  chk_alt_gate: assert property (!pin_select_bit_q[0] |=> alt_out_pins_t1[0] ==
    $past(port_level_t1[0]))
    else $error("unselected alternate pin overridden");

  cov_forced_set: cover property (force_compare_t0 && out_mode_bits_t0_q == toc_pkg::OM_SET);
  cov_blocked_equal: cover property (blk_t0_q && counter_t0_q == act_t0 && run_t0_q);
  cov_phase_turn: cover property (run_t1_q && step_t1.upd && mode_t1_q == toc_pkg::MD_PHASE);

endmodule // toc_top

/* include/toc_pkg.sv */
package toc_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] REG_T0_CTRL = 8'h00;
  localparam logic [7:0] REG_T0_COUNT = 8'h04;
  localparam logic [7:0] REG_T0_CMP = 8'h08;
  localparam logic [7:0] REG_T0_STAT = 8'h0C;
  localparam logic [7:0] REG_T1_CTRL = 8'h10;
  localparam logic [7:0] REG_T1_COUNT = 8'h14;
  localparam logic [7:0] REG_T1_CMPA = 8'h18;
  localparam logic [7:0] REG_T1_CMPB = 8'h1C;
  localparam logic [7:0] REG_T1_STAT = 8'h20;

  // Control word fields
  localparam int unsigned CTL_MODE_LSB = 0;
  localparam int unsigned CTL_RUN = 2;
  localparam int unsigned CTL_OMA_LSB = 4;
  localparam int unsigned CTL_OMB_LSB = 6;
  localparam int unsigned CTL_FORCEA = 8;
  localparam int unsigned CTL_FORCEB = 9;
  localparam int unsigned CTL_SELA = 10;
  localparam int unsigned CTL_SELB = 11;

  // Status word fields
  localparam int unsigned STAT_FLAGA = 0;
  localparam int unsigned STAT_FLAGB = 1;
  localparam int unsigned STAT_STATEA = 2;
  localparam int unsigned STAT_STATEB = 3;

  // Compare output mode codes
  localparam logic [1:0] OM_PORT = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;

  // Counter limits
  localparam logic [15:0] MAX_T0 = 16'h00FF;
  localparam logic [15:0] MAX_T1 = 16'hFFFF;

  // Waveform modes; bit 1 marks the PWM modes
  typedef enum logic [1:0] {
    MD_NORMAL = 2'h0,
    MD_CTC = 2'h1,
    MD_PHASE = 2'h2,
    MD_FAST = 2'h3
  } toc_mode_t;

  // Values after reset
  localparam toc_mode_t RST_MODE = MD_NORMAL;
  localparam logic [1:0] RST_OM = OM_PORT;
  localparam logic RST_STATE = 1'b0;

  // Captured bus address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic in_range;
    logic [7:0] addr;
  } toc_ahb_ap_t;

  // Per-channel control bundle
  typedef struct packed {
    logic pwm;
    logic [1:0] out_mode;
    logic force_cmp;
  } toc_chan_ctl_t;

  // Counter step result
  typedef struct packed {
    logic down;
    logic upd;
    logic [15:0] cnt;
  } toc_step_t;

endpackage

/* hw/toc_chan.sv */
// One output compare channel: buffer, active compare, match and output state
module toc_chan #(
  parameter int W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire toc_pkg::toc_chan_ctl_t ctl,
  input wire logic cmp_wr,
  input wire logic [W-1:0] cmp_wdata,
  input wire logic [W-1:0] count,
  input wire logic running,
  input wire logic block,
  input wire logic update_evt,
  output logic [W-1:0] active,
  output logic match,
  output logic state
);

  logic [W-1:0] buf_q, buf_d; // Software side buffer
  logic [W-1:0] act_q, act_d; // Value the comparator uses
  logic state_q, state_d; // Internal output compare state
  logic fire; // Real or forced match

  // Next values of buffer, active compare and state
  always_comb begin
    buf_d = buf_q;
    act_d = act_q;
    state_d = state_q;
    match = running && !block && (count == act_q);
    fire = match || (ctl.force_cmp && !ctl.pwm);
    if (cmp_wr) begin
      buf_d = cmp_wdata;
    end
    if (cmp_wr && !ctl.pwm) begin
      act_d = cmp_wdata;
    end else if (ctl.pwm && update_evt) begin
      act_d = buf_q;
    end
    // Mode bits act on the state at each match, never on a mode change
    if (fire) begin
      case (ctl.out_mode)
        toc_pkg::OM_TOGGLE: state_d = !state_q;
        toc_pkg::OM_CLEAR: state_d = 1'b0;
        toc_pkg::OM_SET: state_d = 1'b1;
        default: state_d = state_q;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_q <= '0;
      act_q <= '0;
      state_q <= toc_pkg::RST_STATE;
    end else begin
      buf_q <= buf_d;
      act_q <= act_d;
      state_q <= state_d;
    end
  end

  assign active = act_q;
  assign state = state_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_buffer_hold: assert property ((ctl.pwm && !update_evt) |=> $stable(act_q))
    else $error("active compare moved outside an update point");
  chk_buffer_load: assert property ((ctl.pwm && update_evt) |=> act_q == $past(buf_q))
    else $error("buffer not transferred at update point");
  chk_direct_write: assert property ((cmp_wr && !ctl.pwm) |=> act_q == $past(cmp_wdata))
    else $error("direct compare write lost");
  chk_force_toggle: assert property (
    (ctl.force_cmp && !ctl.pwm && ctl.out_mode == toc_pkg::OM_TOGGLE) |=>
    state_q != $past(state_q))
    else $error("forced toggle did not toggle");
  chk_pwm_force_void: assert property ((ctl.force_cmp && ctl.pwm && !match) |=> $stable(state_q))
    else $error("force acted in PWM mode");
  chk_block_match: assert property (block |-> !match)
    else $error("match seen while blocked");
  chk_state_keep: assert property (!fire |=> $stable(state_q))
    else $error("state changed without a match");

endmodule // toc_chan

/* bench/toc_pins_model.sv */
// Port side of the pins: a port data register that the compare logic may override
module toc_pins_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input wire logic [2:0] data,
  output logic port_level_t0,
  output logic [1:0] port_level_t1
);
  timeunit 1ns;
  timeprecision 1ns;
  // Port levels hold until software loads new ones
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {port_level_t1, port_level_t0} <= 3'h0;
    end else if (load) begin
      {port_level_t1, port_level_t0} <= data;
    end
  end
endmodule // toc_pins_model

/* bench/tb.sv */
// Self-checking bench for the output compare unit
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] rd; // Last read word
  logic [2:0] pdata = 3'h0;
  logic pload = 1'b0;
  logic port_level_t0;
  logic out_pin_t0;
  logic override_t0;
  logic [1:0] port_level_t1;
  logic [1:0] alt_out_pins_t1;
  logic [1:0] override_t1;
  logic [31:0] lfsr = 32'h90EC; // Random source
  logic [1:0] oms [5] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h0}; // Output modes tried
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int s0 = 0; // Model of the timer0 output state
  toc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port_level_t0(port_level_t0),
    .port_level_t1(port_level_t1), .out_pin_t0(out_pin_t0),
    .alt_out_pins_t1(alt_out_pins_t1), .override_t0(override_t0), .override_t1(override_t1));
  toc_pins_model u_pins (.hclk(hclk), .hresetn(hresetn), .load(pload), .data(pdata),
    .port_level_t0(port_level_t0), .port_level_t1(port_level_t1));
  // Clock of 40 ns
  always #20 hclk = ~hclk;
  // Hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // Timer0 control word
  function automatic logic [31:0] c0(input logic [1:0] md, input logic run,
    input logic [1:0] om, input logic frc);
    return {23'h0, frc, 2'h0, om, 1'b0, run, md};
  endfunction
  // Next value of the random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Output state after a match for a given output mode
  function automatic int nx(input logic [1:0] om, input int s);
    return (om == 2'h1) ? 1 - s : (om == 2'h2) ? 0 : (om == 2'h3) ? 1 : s;
  endfunction
  // One single AHB transfer; read data taken at the data phase's edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // Compare one result
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Read a register and compare
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // New random port levels
  task automatic new_port();
    lfsr = lfsr_next(lfsr);
    @(posedge hclk);
    pdata <= lfsr[2:0];
    pload <= 1'b1;
    @(posedge hclk);
    pload <= 1'b0;
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(toc_pkg::REG_T0_STAT, 32'h0, "stat0");
    rdchk(toc_pkg::REG_T1_STAT, 32'h0, "stat1");
    // Forced compares in normal mode; state set up before the pin is used
    foreach (oms[i]) begin
      new_port();
      bus(1'b1, toc_pkg::REG_T0_CTRL, c0(2'h0, 1'b0, oms[i], 1'b1));
      s0 = nx(oms[i], s0);
      rdchk(toc_pkg::REG_T0_STAT, s0 << 2, "state0");
      rdchk(toc_pkg::REG_T0_CTRL, c0(2'h0, 1'b0, oms[i], 1'b0), "ctrl0");
      chk("ovr0", {31'h0, oms[i] != 2'h0}, {31'h0, override_t0});
      chk("pin0", (oms[i] != 2'h0) ? s0 : port_level_t0, {31'h0, out_pin_t0});
    end
    $display("test force done");
    bus(1'b1, toc_pkg::REG_T0_CTRL, c0(2'h2, 1'b0, 2'h1, 1'b1));
    rdchk(toc_pkg::REG_T0_STAT, s0 << 2, "state0_pwm");
    bus(1'b1, toc_pkg::REG_T0_CMP, 32'h33);
    rdchk(toc_pkg::REG_T0_CMP, 32'h0, "cmp0_buf");
    bus(1'b1, toc_pkg::REG_T0_CTRL, c0(2'h3, 1'b1, 2'h0, 1'b0));
    repeat (300) @(posedge hclk);
    rdchk(toc_pkg::REG_T0_CMP, 32'h33, "cmp0_top");
    bus(1'b1, toc_pkg::REG_T0_CTRL, c0(2'h0, 1'b0, 2'h0, 1'b0));
    bus(1'b1, toc_pkg::REG_T0_CMP, 32'h20);
    rdchk(toc_pkg::REG_T0_CMP, 32'h20, "cmp0_direct");
    $display("test buffer done");
    bus(1'b1, toc_pkg::REG_T0_COUNT, 32'h40);
    bus(1'b1, toc_pkg::REG_T0_STAT, 32'h1);
    bus(1'b1, toc_pkg::REG_T0_CTRL, c0(2'h0, 1'b1, 2'h1, 1'b0));
    bus(1'b1, toc_pkg::REG_T0_COUNT, 32'h20);
    repeat (8) @(posedge hclk);
    rdchk(toc_pkg::REG_T0_STAT, s0 << 2, "blocked");
    bus(1'b1, toc_pkg::REG_T0_COUNT, 32'h1E);
    repeat (8) @(posedge hclk);
    s0 = 1 - s0;
    rdchk(toc_pkg::REG_T0_STAT, (s0 << 2) | 1, "match");
    bus(1'b1, toc_pkg::REG_T0_CTRL, c0(2'h0, 1'b0, 2'h0, 1'b0));
    $display("test match done");
    new_port();
    bus(1'b1, toc_pkg::REG_T1_CTRL, 32'h7F0);
    rdchk(toc_pkg::REG_T1_STAT, 32'hC, "stat1_force");
    chk("ovr1", 32'h1, {30'h0, override_t1});
    chk("pins1", {30'h0, port_level_t1[1], 1'b1}, {30'h0, alt_out_pins_t1});
    $display("test alternate pins done");
    // Fast PWM with top from channel A; counter written equal to top runs past it
    bus(1'b1, toc_pkg::REG_T1_CMPA, 32'h100);
    bus(1'b1, toc_pkg::REG_T1_CTRL, 32'h7);
    bus(1'b1, toc_pkg::REG_T1_COUNT, 32'h100);
    repeat (8) @(posedge hclk);
    rdchk(toc_pkg::REG_T1_COUNT, 32'h109, "cnt1_past_top");
    bus(1'b1, toc_pkg::REG_T1_CTRL, 32'h0);
    $display("test top skip done");
    finish_test();
  end
endmodule // tb
